// ### time_tag_pkg.sv
// Constants shared by the monitor time tag and pointer block.
// Assumes a 16-bit host register port with word addresses.
package time_tag_pkg;

  // ********************
  // Register port geometry
  // ********************
  localparam int unsigned ADDR_WIDTH = 8;
  localparam int unsigned DATA_WIDTH = 16;
  localparam int unsigned TAG_WIDTH  = 48;

  // ********************
  // Register offsets (word addresses)
  // ********************
  localparam logic [7:0] OFS_MONITOR_CONFIG       = 8'h29;
  localparam logic [7:0] OFS_ADDRESS_LIST_BASE    = 8'h2F;
  localparam logic [7:0] OFS_NEXT_MESSAGE_POINTER = 8'h30;
  localparam logic [7:0] OFS_LAST_MESSAGE_POINTER = 8'h31;
  localparam logic [7:0] OFS_TIME_COUNTER_CONFIG  = 8'h39;
  localparam logic [7:0] OFS_TIME_COUNT_LOW       = 8'h3A;
  localparam logic [7:0] OFS_TIME_COUNT_MID       = 8'h3B;
  localparam logic [7:0] OFS_TIME_COUNT_HIGH      = 8'h3C;
  localparam logic [7:0] OFS_TIME_UTILITY_LOW     = 8'h3D;
  localparam logic [7:0] OFS_TIME_UTILITY_MID     = 8'h3E;
  localparam logic [7:0] OFS_TIME_UTILITY_HIGH    = 8'h3F;
  localparam logic [7:0] OFS_TIME_MATCH_LOW       = 8'h40;
  localparam logic [7:0] OFS_TIME_MATCH_MID       = 8'h41;
  localparam logic [7:0] OFS_TIME_MATCH_HIGH      = 8'h42;

  // ********************
  // Field positions and reset values
  // ********************
  localparam int unsigned BIT_ALWAYS_ONE       = 0;
  localparam int unsigned BIT_WIDE_TIME_TAG    = 1;
  localparam int unsigned BIT_EXTENDED_FLAG    = 2;
  localparam int unsigned CMD_FIELD_LSB        = 14;
  localparam logic [15:0] ADDRESS_LIST_RESET   = 16'h00B0;
  localparam logic [15:0] WORD_ZERO            = 16'h0000;
  localparam logic [47:0] TAG_ZERO             = 48'h0000_0000_0000;
  localparam logic [47:0] TAG_ONE              = 48'h0000_0000_0001;

  // Command buffer entry length in words for each tag width
  localparam logic [3:0] ENTRY_WORDS_NARROW = 4'h4;
  localparam logic [3:0] ENTRY_WORDS_WIDE   = 4'h8;

  // Counter commands written into bits 15-14 of the counter config
  localparam logic [1:0] TAG_CMD_NONE    = 2'h0;
  localparam logic [1:0] TAG_CMD_CLEAR   = 2'h1;
  localparam logic [1:0] TAG_CMD_CAPTURE = 2'h2;
  localparam logic [1:0] TAG_CMD_LOAD    = 2'h3;

  // Pick one 16-bit slice (0 low, 1 mid, 2 high) of a 48-bit value
  function automatic logic [15:0] tag_slice(input logic [47:0] value,
                                            input logic [1:0]  index);
    logic [15:0] slice;
    slice = WORD_ZERO;
    case (index)
      2'h0:    slice = value[15:0];
      2'h1:    slice = value[31:16];
      2'h2:    slice = value[47:32];
      default: slice = WORD_ZERO;
    endcase
    return slice;
  endfunction

endpackage

// ### time_tag_counter.sv
// Free running 16/48-bit time tag counter with clear and load.
// Assumes the tick input is a one-cycle enable from the time base.
`timescale 1ns/1ps
`default_nettype none
module time_tag_counter (
  input  wire logic                             sys_clk,
  input  wire logic                             resetn,
  input  wire logic                             tick,
  input  wire logic                             wide_mode,
  input  wire logic                             clear_cmd,
  input  wire logic                             load_cmd,
  input  wire logic [time_tag_pkg::TAG_WIDTH-1:0] load_value,
  output logic      [time_tag_pkg::TAG_WIDTH-1:0] count_q
);
  import time_tag_pkg::*;

  logic [47:0] count_d;
  logic [47:0] step;

  // ********************
  // Next count: clear, then load, then tick
  // ********************
  always_comb begin
    step    = count_q + TAG_ONE;
    count_d = count_q;
    if (clear_cmd) begin
      count_d = TAG_ZERO;
    end else if (load_cmd) begin
      count_d[15:0] = load_value[15:0];
      if (wide_mode) begin
        count_d[47:16] = load_value[47:16];
      end
    end else if (tick) begin
      if (wide_mode) begin
        count_d = step;
      end else begin
        count_d[15:0] = step[15:0];
      end
    end
  end

  // Count register; master reset or a clear command clears it, soft reset does not
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      count_q <= TAG_ZERO;
    end else begin
      count_q <= count_d;
    end
  end

endmodule
`default_nettype wire

// ### time_tag_match.sv
// Time tag match detector producing a one-cycle event.
// Assumes the enable comes from the host interrupt enable register.
`timescale 1ns/1ps
`default_nettype none
module time_tag_match (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        wide_mode,
  input  wire logic        irq_enable,
  input  wire logic [47:0] count,
  input  wire logic [47:0] match_value,
  output logic             match_event_q
);
  import time_tag_pkg::*;

  logic equal;
  logic equal_q;

  // Only the low word counts in 16-bit mode
  assign equal = (count[15:0] == match_value[15:0]) &&
                 (!wide_mode ||
                  (count[47:16] == match_value[47:16]));

  // Event on the first cycle of equality, so a held count fires once
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      equal_q       <= 1'b0;
      match_event_q <= 1'b0;
    end else begin
      equal_q       <= equal;
      match_event_q <= equal && !equal_q && irq_enable;
    end
  end

endmodule
`default_nettype wire

// ### monitor_time_tag_pointers.sv
// Bus monitor configuration, message pointers and time tag registers.
// Assumes a host register port already decoded from the serial link,
// with one-cycle read and write strobes on an 8-bit word address, and
// a monitor core that reports message completion with a strobe.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Config bit 2 enables extended status flags
// - Bit 1 clear: 16-bit tag, four-word entries
// - Bit 1 set: 48-bit tag, eight-word entries
// - Config bit 0 always reads one
// - Address list base writable, resets 0x00B0
// - Soft reset leaves address list base alone
// - Next pointer read-only, updated at message completion
// - Next pointer mirrors address list word one
// - Last pointer read-only; pointers clear on resets
// - Narrow mode: low register holds whole count
// - Wide mode: count split low, mid, high
// - Count registers ignore writes; use commands
// - Config bits 15-14 clear, capture or load
// - Load copies utility words into count
// - Capture copies count words into utility
// - Utility registers read-write, cleared on reset
// - Raise event when count equals match
// - Narrow compares low only; wide compares all
// - Match event only with enable bit set
module monitor_time_tag_pointers (
  input  wire logic                                sys_clk,
  input  wire logic                                resetn,
  input  wire logic                                monitor_soft_reset,
  input  wire logic [time_tag_pkg::ADDR_WIDTH-1:0] reg_addr,
  input  wire logic                                reg_write,
  input  wire logic                                reg_read,
  input  wire logic [time_tag_pkg::DATA_WIDTH-1:0] reg_wdata,
  output logic      [time_tag_pkg::DATA_WIDTH-1:0] reg_rdata_q,
  output logic                                     reg_rvalid_q,
  output logic                                     reg_hit_q,
  input  wire logic                                time_tick,
  input  wire logic                                message_done,
  input  wire logic [time_tag_pkg::DATA_WIDTH-1:0] message_start_addr,
  input  wire logic [time_tag_pkg::DATA_WIDTH-1:0] list_word1_pointer,
  input  wire logic                           monitor_time_match_irq_enable,
  output logic                                     extended_flag_enable,
  output logic                                     wide_time_tag_select,
  output logic      [3:0]                          entry_word_count,
  output logic      [time_tag_pkg::DATA_WIDTH-1:0] address_list_base_q,
  output logic      [time_tag_pkg::TAG_WIDTH-1:0]  time_count,
  output logic                                     time_match_event_q
);
  import time_tag_pkg::*;

  // ********************
  // Storage
  // ********************
  logic        extended_flag_q;
  logic        wide_tag_q;
  logic [15:0] next_message_pointer_q;
  logic [15:0] last_message_pointer_q;
  logic [47:0] utility_q;
  logic [47:0] match_q;
  logic [47:0] count_q;
  logic [15:0] read_word;
  logic        read_hit;
  logic        write_command;
  logic [1:0]  command;
  logic        clear_cmd;
  logic        capture_cmd;
  logic        load_cmd;

  // ********************
  // Counter command decode
  // ********************

  // A write to the counter config carries the command in bits 15-14
  assign write_command = reg_write && (reg_addr == OFS_TIME_COUNTER_CONFIG);
  assign command       = reg_wdata[CMD_FIELD_LSB +: 2];
  assign clear_cmd     = write_command && (command == TAG_CMD_CLEAR);
  assign capture_cmd   = write_command && (command == TAG_CMD_CAPTURE);
  assign load_cmd      = write_command && (command == TAG_CMD_LOAD);

  // ********************
  // Monitor configuration
  // ********************

  // Extended flags and tag width; bit 0 is hard-wired on read
  always_ff @(posedge sys_clk) begin
    if (!resetn || monitor_soft_reset) begin
      extended_flag_q <= 1'b0;
      wide_tag_q      <= 1'b0;
    end else if (reg_write && (reg_addr == OFS_MONITOR_CONFIG)) begin
      extended_flag_q <= reg_wdata[BIT_EXTENDED_FLAG];
      wide_tag_q      <= reg_wdata[BIT_WIDE_TIME_TAG];
    end
  end

  // Status word recorder takes the flag set and entry length from here
  assign extended_flag_enable = extended_flag_q;
  assign wide_time_tag_select = wide_tag_q;
  assign entry_word_count     = wide_tag_q ? ENTRY_WORDS_WIDE
                                           : ENTRY_WORDS_NARROW;

  // ********************
  // Address list base
  // ********************

  // Master reset only; a soft reset must not lose the table base
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      address_list_base_q <= ADDRESS_LIST_RESET;
    end else if (reg_write && (reg_addr == OFS_ADDRESS_LIST_BASE)) begin
      address_list_base_q <= reg_wdata;
    end
  end

  // ********************
  // Message pointers
  // ********************

  // Both pointers load only when a message completes; master or soft reset clears them
  always_ff @(posedge sys_clk) begin
    if (!resetn || monitor_soft_reset) begin
      next_message_pointer_q <= WORD_ZERO;
      last_message_pointer_q <= WORD_ZERO;
    end else if (message_done) begin
      next_message_pointer_q <= list_word1_pointer;
      last_message_pointer_q <= message_start_addr;
    end
  end

  // ********************
  // Time tag utility registers
  // ********************

  // Host writes, or a capture of the running count
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      utility_q <= TAG_ZERO;
    end else if (capture_cmd) begin
      utility_q[15:0] <= count_q[15:0];
      if (wide_tag_q) begin
        utility_q[47:16] <= count_q[47:16];
      end
    end else if (reg_write) begin
      case (reg_addr)
        OFS_TIME_UTILITY_LOW: begin
          utility_q[15:0] <= reg_wdata;
        end
        OFS_TIME_UTILITY_MID: begin
          utility_q[31:16] <= reg_wdata;
        end
        OFS_TIME_UTILITY_HIGH: begin
          utility_q[47:32] <= reg_wdata;
        end
        default: begin
          utility_q <= utility_q;
        end
      endcase
    end
  end

  // ********************
  // Time tag match registers
  // ********************

  // Plain host storage, cleared on master reset
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      match_q <= TAG_ZERO;
    end else if (reg_write) begin
      case (reg_addr)
        OFS_TIME_MATCH_LOW: begin
          match_q[15:0] <= reg_wdata;
        end
        OFS_TIME_MATCH_MID: begin
          match_q[31:16] <= reg_wdata;
        end
        OFS_TIME_MATCH_HIGH: begin
          match_q[47:32] <= reg_wdata;
        end
        default: begin
          match_q <= match_q;
        end
      endcase
    end
  end

  // ********************
  // Counter and match detector
  // ********************

  // Count offsets are not write-decoded, so host writes drop there
  time_tag_counter u_counter (
    .sys_clk    (sys_clk),
    .resetn     (resetn),
    .tick       (time_tick),
    .wide_mode  (wide_tag_q),
    .clear_cmd  (clear_cmd),
    .load_cmd   (load_cmd),
    .load_value (utility_q),
    .count_q    (count_q)
  );

  time_tag_match u_match (
    .sys_clk       (sys_clk),
    .resetn        (resetn),
    .wide_mode     (wide_tag_q),
    .irq_enable    (monitor_time_match_irq_enable),
    .count         (count_q),
    .match_value   (match_q),
    .match_event_q (time_match_event_q)
  );

  // Count shown to the message recorder for time stamping
  assign time_count = count_q;

  // ********************
  // Read path
  // ********************

  // Mux the addressed word; unmapped addresses answer zero
  always_comb begin
    read_word = WORD_ZERO;
    read_hit  = 1'b1;
    case (reg_addr)
      OFS_MONITOR_CONFIG: begin
        read_word                    = WORD_ZERO;
        read_word[BIT_EXTENDED_FLAG] = extended_flag_q;
        read_word[BIT_WIDE_TIME_TAG] = wide_tag_q;
        read_word[BIT_ALWAYS_ONE]    = 1'b1;
      end
      OFS_ADDRESS_LIST_BASE: begin
        read_word = address_list_base_q;
      end
      OFS_NEXT_MESSAGE_POINTER: begin
        read_word = next_message_pointer_q;
      end
      OFS_LAST_MESSAGE_POINTER: begin
        read_word = last_message_pointer_q;
      end
      OFS_TIME_COUNTER_CONFIG: begin
        read_word = WORD_ZERO;
      end
      OFS_TIME_COUNT_LOW: begin
        read_word = tag_slice(count_q, 2'h0);
      end
      OFS_TIME_COUNT_MID: begin
        read_word = tag_slice(count_q, 2'h1);
      end
      OFS_TIME_COUNT_HIGH: begin
        read_word = tag_slice(count_q, 2'h2);
      end
      OFS_TIME_UTILITY_LOW: begin
        read_word = tag_slice(utility_q, 2'h0);
      end
      OFS_TIME_UTILITY_MID: begin
        read_word = tag_slice(utility_q, 2'h1);
      end
      OFS_TIME_UTILITY_HIGH: begin
        read_word = tag_slice(utility_q, 2'h2);
      end
      OFS_TIME_MATCH_LOW: begin
        read_word = tag_slice(match_q, 2'h0);
      end
      OFS_TIME_MATCH_MID: begin
        read_word = tag_slice(match_q, 2'h1);
      end
      OFS_TIME_MATCH_HIGH: begin
        read_word = tag_slice(match_q, 2'h2);
      end
      default: begin
        read_word = WORD_ZERO;
        read_hit  = 1'b0;
      end
    endcase
  end

  // Read data is registered and held until the next read
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      reg_rdata_q  <= WORD_ZERO;
      reg_rvalid_q <= 1'b0;
      reg_hit_q    <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_read;
      if (reg_read) begin
        reg_rdata_q <= read_word;
        reg_hit_q   <= read_hit;
      end
    end
  end

endmodule
`default_nettype wire

// ### host_reg_model.sv
// Host side of the register port: one-cycle read and write strobes.
// Assumes the device answers a read one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module host_reg_model (
  input  wire logic        sys_clk,
  input  wire logic        reg_rvalid_q,
  input  wire logic [15:0] reg_rdata_q,
  output logic      [7:0]  reg_addr,
  output logic             reg_write,
  output logic             reg_read,
  output logic      [15:0] reg_wdata
);
  // Idle bus at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_write = 1'h0;
    reg_read  = 1'h0;
    reg_wdata = 16'h0000;
  end

  // Write strobe for one edge; released lines show the inverse value
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(negedge sys_clk);
    reg_write <= 1'h0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  // Read strobe for one edge; the answer is taken one cycle later
  task automatic rd(input logic [7:0] a, output logic [15:0] d,
                    output logic ok);
    @(negedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(negedge sys_clk);
    reg_read <= 1'h0;
    reg_addr <= ~a;
    ok = reg_rvalid_q;
    d  = reg_rdata_q;
  endtask
endmodule
`default_nettype wire

// ### monitor_time_tag_pointers_props.sv
// Checker for the time tag and pointer block, bound to its top.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module monitor_time_tag_pointers_props
  import time_tag_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        monitor_soft_reset,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata_q,
  input wire logic        time_tick,
  input wire logic        monitor_time_match_irq_enable,
  input wire logic        extended_flag_enable,
  input wire logic        wide_time_tag_select,
  input wire logic [3:0]  entry_word_count,
  input wire logic [15:0] address_list_base_q,
  input wire logic [47:0] time_count,
  input wire logic        time_match_event_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // Host write that carries a counter command
  logic cmd_wr;
  assign cmd_wr = reg_write && reg_addr == OFS_TIME_COUNTER_CONFIG
                  && reg_wdata[15:14] != TAG_CMD_NONE;

  a_config_bit_one: assert property (
    reg_read && reg_addr == OFS_MONITOR_CONFIG |=> reg_rdata_q[0])
    else $error("config bit 0 read as zero");
  a_entry_narrow: assert property (
    !wide_time_tag_select |-> entry_word_count == ENTRY_WORDS_NARROW)
    else $error("narrow entry length wrong");
  a_entry_wide: assert property (
    wide_time_tag_select |-> entry_word_count == ENTRY_WORDS_WIDE)
    else $error("wide entry length wrong");
  a_ext_flag_write: assert property (
    reg_write && reg_addr == OFS_MONITOR_CONFIG && !monitor_soft_reset
    |=> extended_flag_enable == $past(reg_wdata[2]))
    else $error("extended flag not taken from write");
  a_base_reset: assert property (
    $rose(resetn) |-> address_list_base_q == ADDRESS_LIST_RESET)
    else $error("list base wrong after reset");
  a_base_soft_keep: assert property (
    monitor_soft_reset && !(reg_write && reg_addr == OFS_ADDRESS_LIST_BASE)
    |=> $stable(address_list_base_q))
    else $error("list base moved on soft reset");
  a_narrow_tick: assert property (
    time_tick && !wide_time_tag_select && !cmd_wr
    |=> time_count[15:0] == $past(time_count[15:0]) + 16'h0001)
    else $error("narrow count did not step");
  a_narrow_upper: assert property (
    !wide_time_tag_select && !cmd_wr |=> $stable(time_count[47:16]))
    else $error("upper count moved in narrow mode");
  a_wide_tick: assert property (
    time_tick && wide_time_tag_select && !cmd_wr
    |=> time_count == $past(time_count) + TAG_ONE)
    else $error("wide count did not step");
  a_count_idle: assert property (
    !time_tick && !cmd_wr |=> $stable(time_count))
    else $error("count moved without tick or command");
  a_clear_low: assert property (
    cmd_wr && reg_wdata[15:14] == TAG_CMD_CLEAR
    |=> time_count[15:0] == WORD_ZERO)
    else $error("clear left count nonzero");
  a_match_gate: assert property (
    !monitor_time_match_irq_enable |=> !time_match_event_q)
    else $error("match event while disabled");
  a_match_single: assert property (
    time_match_event_q |=> !time_match_event_q)
    else $error("match event longer than one cycle");
endmodule

bind monitor_time_tag_pointers monitor_time_tag_pointers_props i_props (
  .sys_clk(sys_clk), .resetn(resetn),
  .monitor_soft_reset(monitor_soft_reset), .reg_addr(reg_addr),
  .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
  .reg_rdata_q(reg_rdata_q), .time_tick(time_tick),
  .monitor_time_match_irq_enable(monitor_time_match_irq_enable),
  .extended_flag_enable(extended_flag_enable),
  .wide_time_tag_select(wide_time_tag_select),
  .entry_word_count(entry_word_count),
  .address_list_base_q(address_list_base_q),
  .time_count(time_count), .time_match_event_q(time_match_event_q)
);
`default_nettype wire

// ### monitor_time_tag_and_pointers_tb.sv
// Self-checking bench for the time tag and pointer block.
// Assumes host_reg_model drives the register port; the bench plays
// the monitor core and the time base.
`timescale 1ns/1ps
`default_nettype none
module monitor_time_tag_and_pointers_tb;
  import time_tag_pkg::*;

  logic        sys_clk = 1'h0;
  logic        resetn = 1'h0;
  logic        soft_rst = 1'h0;
  logic        time_tick = 1'h0;
  logic        message_done = 1'h0;
  logic        irq_en = 1'h0;
  logic [15:0] start_addr = 16'h0000;
  logic [15:0] word1_ptr = 16'h0000;
  logic [7:0]  reg_addr;
  logic        reg_write, reg_read, reg_rvalid_q, reg_hit_q;
  logic [15:0] reg_wdata, reg_rdata_q, address_list_base_q;
  logic        extended_flag_enable, wide_time_tag_select;
  logic        time_match_event_q;
  logic [3:0]  entry_word_count;
  logic [47:0] time_count;
  int          miscompares = 0;
  int          n_compared = 0;

  // 10 MHz clock
  always #50 sys_clk = ~sys_clk;

  monitor_time_tag_pointers i_dut (
    .sys_clk(sys_clk), .resetn(resetn), .monitor_soft_reset(soft_rst),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .reg_hit_q(reg_hit_q),
    .time_tick(time_tick), .message_done(message_done),
    .message_start_addr(start_addr), .list_word1_pointer(word1_ptr),
    .monitor_time_match_irq_enable(irq_en),
    .extended_flag_enable(extended_flag_enable),
    .wide_time_tag_select(wide_time_tag_select),
    .entry_word_count(entry_word_count),
    .address_list_base_q(address_list_base_q),
    .time_count(time_count), .time_match_event_q(time_match_event_q));

  host_reg_model i_host (
    .sys_clk(sys_clk), .reg_rvalid_q(reg_rvalid_q),
    .reg_rdata_q(reg_rdata_q), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata));

  // ********************
  // Expectations and compares
  // ********************
  function automatic logic [15:0] cfg_exp(input logic [15:0] d);
    return {13'h0000, d[2:1], 1'h1};
  endfunction

  function automatic logic [15:0] entry_exp(input logic w);
    return w ? 16'h0008 : 16'h0004;
  endfunction

  task automatic chk_word(input logic [15:0] got, exp, input string s);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic chk_tag(input logic [47:0] got, exp, input string s);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp,
                        input string s);
    logic [15:0] d;
    logic        ok;
    i_host.rd(a, d, ok);
    if (ok !== 1'h1) begin
      miscompares++;
      $display("mismatch at %0t: no read answer", $time);
      summarize();
    end else begin
      chk_word(d, exp, s);
    end
  endtask

  // ********************
  // Stimulus helpers
  // ********************
  task automatic wr48(input logic [7:0] a, input logic [47:0] v);
    i_host.wr(a, v[15:0]);
    i_host.wr(a + 8'h01, v[31:16]);
    i_host.wr(a + 8'h02, v[47:32]);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      time_tick = 1'h1;
      @(negedge sys_clk);
      time_tick = 1'h0;
    end
  endtask

  task automatic do_reset();
    @(negedge sys_clk);
    resetn = 1'h0;
    repeat (5) @(negedge sys_clk);
    resetn = 1'h1;
  endtask

  // Bounded wait for the match pulse, then check it is one cycle wide
  task automatic wait_match(input logic fire);
    int n;
    n = 0;
    while (time_match_event_q !== 1'h1 && n < 6) begin
      @(negedge sys_clk);
      n++;
    end
    chk_word({15'h0000, n < 6}, {15'h0000, fire}, "match event");
    if (fire && n == 6) begin
      summarize();
    end else begin
      @(negedge sys_clk);
      chk_word({15'h0000, time_match_event_q}, WORD_ZERO, "pulse");
    end
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ********************
  // Main sequence
  // ********************
  initial begin
    int          i;
    logic [15:0] d, b;
    logic [47:0] u;
    void'($urandom(76));
    repeat (5) @(negedge sys_clk);
    resetn = 1'h1;
    rd_chk(OFS_MONITOR_CONFIG, 16'h0001, "config");
    rd_chk(OFS_ADDRESS_LIST_BASE, ADDRESS_LIST_RESET, "base");
    rd_chk(OFS_NEXT_MESSAGE_POINTER, WORD_ZERO, "next");
    rd_chk(OFS_LAST_MESSAGE_POINTER, WORD_ZERO, "last");
    for (i = 8'h3A; i <= 8'h42; i++)
      rd_chk(8'(i), WORD_ZERO, "time regs");
    chk_word({15'h0000, reg_hit_q}, 16'h0001, "hit");
    rd_chk(8'h00, WORD_ZERO, "unmapped");
    chk_word({15'h0000, reg_hit_q}, WORD_ZERO, "hit");
    $display("test reset_values done");
    for (i = 0; i < 8; i++) begin
      d = {13'($urandom), 3'(i)};
      i_host.wr(OFS_MONITOR_CONFIG, d);
      rd_chk(OFS_MONITOR_CONFIG, cfg_exp(d), "config");
      chk_word({15'h0000, extended_flag_enable}, {15'h0000, d[2]}, "xf");
      chk_word({12'h000, entry_word_count}, entry_exp(d[1]), "ent");
    end
    $display("test config done");
    b = 16'($urandom);
    d = 16'($urandom);
    i_host.wr(OFS_ADDRESS_LIST_BASE, b);
    rd_chk(OFS_ADDRESS_LIST_BASE, b, "base");
    message_done = 1'h1;
    start_addr = d;
    word1_ptr = ~d;
    @(negedge sys_clk);
    message_done = 1'h0;
    start_addr = ~d;
    word1_ptr = d;
    i_host.wr(OFS_NEXT_MESSAGE_POINTER, d);
    rd_chk(OFS_NEXT_MESSAGE_POINTER, ~d, "next");
    rd_chk(OFS_LAST_MESSAGE_POINTER, d, "last");
    soft_rst = 1'h1;
    @(negedge sys_clk);
    soft_rst = 1'h0;
    rd_chk(OFS_NEXT_MESSAGE_POINTER, WORD_ZERO, "next");
    rd_chk(OFS_LAST_MESSAGE_POINTER, WORD_ZERO, "last");
    rd_chk(OFS_ADDRESS_LIST_BASE, b, "base kept");
    do_reset();
    rd_chk(OFS_ADDRESS_LIST_BASE, ADDRESS_LIST_RESET, "base");
    $display("test pointers done");
    u = {16'($urandom), 16'($urandom), 16'($urandom)};
    wr48(OFS_TIME_UTILITY_LOW, u);
    i_host.wr(OFS_TIME_COUNTER_CONFIG, 16'hC000);
    chk_tag(time_count, {32'h0, u[15:0]}, "narrow load");
    i_host.wr(OFS_TIME_COUNT_LOW, ~u[15:0]);
    rd_chk(OFS_TIME_COUNT_LOW, u[15:0], "count");
    i_host.wr(OFS_TIME_UTILITY_LOW, 16'hFFFF);
    i_host.wr(OFS_TIME_COUNTER_CONFIG, 16'hC000);
    ticks(3);
    chk_tag(time_count, 48'h0000_0000_0002, "wrap");
    i_host.wr(OFS_TIME_COUNTER_CONFIG, 16'h8000);
    rd_chk(OFS_TIME_UTILITY_LOW, 16'h0002, "capture");
    rd_chk(OFS_TIME_UTILITY_MID, u[31:16], "capture");
    i_host.wr(OFS_TIME_COUNTER_CONFIG, 16'h4000);
    rd_chk(OFS_TIME_COUNT_LOW, WORD_ZERO, "clear");
    $display("test narrow done");
    i_host.wr(OFS_MONITOR_CONFIG, 16'h0002);
    u = {16'($urandom), 16'($urandom), 16'($urandom)};
    wr48(OFS_TIME_UTILITY_LOW, u);
    i_host.wr(OFS_TIME_COUNTER_CONFIG, 16'hC000);
    chk_tag(time_count, u, "wide load");
    ticks(3);
    u = u + 48'h3;
    for (i = 0; i < 3; i++)
      rd_chk(OFS_TIME_COUNT_LOW + 8'(i), u[16*i +: 16], "wide");
    i_host.wr(OFS_TIME_COUNTER_CONFIG, 16'h8000);
    rd_chk(OFS_TIME_UTILITY_HIGH, u[47:32], "capture");
    wr48(OFS_TIME_UTILITY_LOW, 48'hFFFF_FFFF_FFFF);
    i_host.wr(OFS_TIME_COUNTER_CONFIG, 16'hC000);
    ticks(1);
    chk_tag(time_count, TAG_ZERO, "wide wrap");
    $display("test wide done");
    for (i = 0; i < 2; i++) begin
      i_host.wr(OFS_MONITOR_CONFIG, {14'h0000, 1'(i), 1'h0});
      u = {16'($urandom), 16'($urandom), 16'($urandom)};
      wr48(OFS_TIME_MATCH_LOW, u);
      wr48(OFS_TIME_UTILITY_LOW, u - 48'h2);
      irq_en = 1'h1;
      i_host.wr(OFS_TIME_COUNTER_CONFIG, 16'hC000);
      ticks(2);
      wait_match(1'h1);
      irq_en = 1'h0;
      i_host.wr(OFS_TIME_COUNTER_CONFIG, 16'hC000);
      ticks(2);
      wait_match(1'h0);
    end
    $display("test match done");
    summarize();
  end
endmodule
`default_nettype wire
